// ==== logic/rbr_pkg.sv ====
// shared offsets, reset values and codes of the baseband register group
package rbr_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] OFF_INT_ENABLE = 8'h00;
  localparam logic [7:0] OFF_INT_FLAGS  = 8'h01;
  localparam logic [7:0] OFF_PIN_SEL_A  = 8'h02;
  localparam logic [7:0] OFF_PIN_SEL_B  = 8'h03;
  localparam logic [7:0] OFF_PIN_PULL   = 8'h04;
  localparam logic [7:0] OFF_FIFO_START = 8'h05;
  localparam logic [7:0] OFF_FIFO_MODE  = 8'h06;
  localparam logic [7:0] OFF_PREAMBLE   = 8'h07;
  localparam logic [7:0] OFF_PKT_CTRL   = 8'h08;
  localparam logic [7:0] OFF_MISC_CTRL  = 8'h09;
  // reset values
  localparam logic [7:0] RST_INT_ENABLE = 8'h00;
  localparam logic [7:0] RST_INT_FLAGS  = 8'h00;
  localparam logic [7:0] RST_PIN_SEL_A  = 8'h40;
  localparam logic [7:0] RST_PIN_SEL_B  = 8'h00;
  localparam logic [7:0] RST_PIN_PULL   = 8'h7f;
  localparam logic [7:0] RST_FIFO_START = 8'h00;
  localparam logic [7:0] RST_FIFO_MODE  = 8'h01;
  localparam logic [7:0] RST_PREAMBLE   = 8'h01;
  localparam logic [7:0] RST_PKT_CTRL   = 8'h24;
  localparam logic [7:0] RST_MISC_CTRL  = 8'h09;
  // writable bits; the rest read as stored reserved values
  localparam logic [7:0] MSK_PIN_PULL   = 8'hde;
  localparam logic [7:0] MSK_FIFO_START = 8'h3f;
  localparam logic [7:0] MSK_FIFO_MODE  = 8'h1f;
  localparam logic [7:0] MSK_PKT_CTRL   = 8'hfc;
  // interrupt flag positions
  localparam int BIT_ACK_FAIL = 7;
  localparam int BIT_CYCLE    = 6;
  localparam int BIT_FIFO_LOW = 5;
  localparam int BIT_RX_ERR   = 4;
  localparam int BIT_RX_EVT   = 3;
  localparam int BIT_CAL_DONE = 2;
  localparam int BIT_RX_DONE  = 1;
  localparam int BIT_TX_DONE  = 0;
  // smallest fifo margin in bytes, doubled per select step
  localparam logic [6:0] MARGIN_BASE = 7'h04;
  // pin function codes
  typedef enum logic [3:0] {
    PF_NONE    = 4'h0, PF_SDO     = 4'h1, PF_DIRECT_BIDIR_DATA   = 4'h2,
    PF_TXD     = 4'h3, PF_RXD     = 4'h4, PF_IRQ    = 4'h5,
    PF_TMR_CLK = 4'h6, PF_UNUSED  = 4'h7, PF_TX_BIT_CLOCK  = 4'h8,
    PF_RX_RECOVERED_CLOCK   = 4'h9, PF_XCLK    = 4'ha, PF_LOW_SPEED_RC_OSC   = 4'hb,
    PF_PA_EN   = 4'hc, PF_LNA_EN  = 4'hd, PF_TXRX_BIT_CLOCK = 4'he,
    PF_PDB     = 4'hf
  } rbr_pin_fn_t;
endpackage : rbr_pkg

// ==== logic/rbr_regs.sv ====
// baseband interrupt, pin, fifo and packet control register group
//
// Summary of operation
// - eight flags, enables at matching bit positions
// - write clearing value to clear only those flags
// - cycle timer full sets cycle timer flag
// - burst tx: low data, more pending sets flag
// - burst rx: low space, more remaining sets flag
// - rx fail, crc mismatch, overwrite set error
// - carrier or sync detect sets event flag
// - calibration done per auto calibration mode
// - rx done flag only without errors
// - pins one, two decode three-bit function
// - pins three, four decode four-bit function
// - code 1110 bit clock, 1111 power-down-bar
// - pin settings cleared by power-on only
// - serial pull-up and four general pull-ups
// - six-bit tx fifo start address
// - store received length byte when enabled
// - margin select 4/8/16/32, detect enable
// - preamble words equal length value plus one
// - packet id into header top bits
// - two-bit whitening format select
// - sync length from three bits plus one
// - clear polarity picks zero or one
// - interrupt pin polarity follows output polarity
// - detect source 00 carrier, 1x sync
`timescale 1ns/1ps
`default_nettype none
module rbr_regs (
  // clock and resets
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       sw_reset,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // baseband events and status
  input  wire logic       ev_ack_tx_fail,
  input  wire logic       ev_cycle_timer_full,
  input  wire logic       burst_tx_mode,
  input  wire logic       burst_rx_mode,
  input  wire logic [6:0] tx_fifo_level,
  input  wire logic       tx_data_pending,
  input  wire logic [6:0] rx_fifo_space,
  input  wire logic [7:0] rx_remaining_len,
  input  wire logic       ev_rx_fail,
  input  wire logic       ev_crc_mismatch,
  input  wire logic       crc_field_enable,
  input  wire logic       ev_rx_overwrite,
  input  wire logic       ev_carrier_detect,
  input  wire logic       ev_sync_detect,
  input  wire logic       ev_low_speed_rc_osc_cal_done,
  input  wire logic       ev_vco_cal_done,
  input  wire logic       ev_rc_cal_done,
  input  wire logic       ev_rx_finished,
  input  wire logic       ev_tx_done,
  // signals routed to the general pins
  input  wire logic       rx_mode,
  input  wire logic       sdo_data,
  input  wire logic       sdo_active,
  input  wire logic       direct_rx_data,
  input  wire logic       tx_bit_clock,
  input  wire logic       rx_recovered_clock,
  input  wire logic       divided_crystal_clock,
  input  wire logic       low_speed_rc_osc,
  input  wire logic       ext_power_amp_enable,
  input  wire logic       ext_low_noise_amp_enable,
  input  wire logic       power_down_bar_out,
  // general pins 4..1 as bits 3..0
  input  wire logic [3:0] gio_i,
  output logic      [3:0] gio_o,
  output logic      [3:0] gio_oe,
  output logic      [3:0] general_pins_pullup_enable,
  output logic            serial_pins_pullup_enable,
  output logic      [1:0] pad_drive_strength,
  output logic            direct_tx_data,
  output logic            ext_timer_clock_in,
  // settings for the packet and fifo logic
  output logic      [5:0] tx_fifo_start_addr,
  output logic            rx_length_byte_store_enable,
  output logic            fifo_unlimited_length_enable,
  output logic      [8:0] tx_preamble_words,
  output logic      [7:0] payload_header_top,
  output logic            trailer_enable,
  output logic      [1:0] whitening_format,
  output logic      [3:0] sync_word_len,
  output logic      [1:0] rx_detect_source
);

  logic [7:0] int_en_r;
  logic [7:0] flags_r;
  logic [7:0] pin_a_r;
  logic [7:0] pin_b_r;
  logic [7:0] pull_r;
  logic [7:0] fifo_start_r;
  logic [7:0] fifo_mode_r;
  logic [7:0] preamble_r;
  logic [7:0] pkt_r;
  logic [7:0] misc_r;
  logic [7:0] flags_nxt;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] rdata_nxt;
  logic [6:0] margin;
  logic       low_cond;
  logic       low_cond_r;
  logic       vco_seen_r;
  logic       rc_seen_r;
  logic       cal_set;
  logic       rx_err_now;
  logic       irq_req;
  logic [3:0] gio_s1_r;
  logic [3:0] gio_s2_r;
  logic [3:0] pin_fn [4];

  wire wr_hit = reg_wr;
  wire flag_clr_pol = misc_r[1];
  wire int_out_pol  = misc_r[0];
  wire auto_cal_en  = misc_r[4];

  // margin doubles with each select step: 4, 8, 16, 32 bytes
  assign margin = MARGIN_BASE_SHIFT(fifo_mode_r[1:0]);

  function automatic logic [6:0] MARGIN_BASE_SHIFT(input logic [1:0] s);
    MARGIN_BASE_SHIFT = rbr_pkg::MARGIN_BASE << s;
  endfunction : MARGIN_BASE_SHIFT

  always_comb begin
    low_cond = 1'b0;
    if (fifo_mode_r[2]) begin
      if (burst_tx_mode)
        low_cond = (tx_fifo_level < margin) && tx_data_pending;
      else if (burst_rx_mode)
        low_cond = (rx_fifo_space < margin) &&
                   (rx_remaining_len > {1'b0, margin});
    end
  end

  assign rx_err_now = ev_rx_fail | (ev_crc_mismatch & crc_field_enable) |
                      ev_rx_overwrite;
  assign cal_set = auto_cal_en ?
                   ((vco_seen_r | ev_vco_cal_done) &
                    (rc_seen_r | ev_rc_cal_done)) :
                   ev_low_speed_rc_osc_cal_done;

  always_comb begin
    flag_set = 8'h00;
    flag_set[rbr_pkg::BIT_ACK_FAIL] = ev_ack_tx_fail;
    flag_set[rbr_pkg::BIT_CYCLE]    = ev_cycle_timer_full;
    flag_set[rbr_pkg::BIT_FIFO_LOW] = low_cond & ~low_cond_r;
    flag_set[rbr_pkg::BIT_RX_ERR]   = rx_err_now;
    flag_set[rbr_pkg::BIT_RX_EVT]   = misc_r[3] ? ev_sync_detect :
                                      (misc_r[2] ? 1'b0 :
                                       ev_carrier_detect);
    flag_set[rbr_pkg::BIT_CAL_DONE] = cal_set;
    flag_set[rbr_pkg::BIT_RX_DONE]  = ev_rx_finished & ~rx_err_now;
    flag_set[rbr_pkg::BIT_TX_DONE]  = ev_tx_done;
  end

  // clearing value chosen by polarity; a fresh event beats the clear
  always_comb begin
    flag_clr = 8'h00;
    if (wr_hit && reg_addr == rbr_pkg::OFF_INT_FLAGS)
      flag_clr = flag_clr_pol ? reg_wdata : ~reg_wdata;
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r    <= rbr_pkg::RST_INT_FLAGS;
      low_cond_r <= 1'b0;
    end else if (sw_reset) begin
      flags_r    <= rbr_pkg::RST_INT_FLAGS;
      low_cond_r <= 1'b0;
    end else begin
      flags_r    <= flags_nxt;
      low_cond_r <= low_cond;
    end
  end

  // both auto calibrations must finish, in any order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_seen_r <= 1'b0;
      rc_seen_r  <= 1'b0;
    end else if (sw_reset || !auto_cal_en || cal_set) begin
      vco_seen_r <= 1'b0;
      rc_seen_r  <= 1'b0;
    end else begin
      vco_seen_r <= vco_seen_r | ev_vco_cal_done;
      rc_seen_r  <= rc_seen_r | ev_rc_cal_done;
    end
  end

  // pin settings survive a software reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_r <= rbr_pkg::RST_PIN_SEL_A;
      pin_b_r <= rbr_pkg::RST_PIN_SEL_B;
      pull_r  <= rbr_pkg::RST_PIN_PULL;
    end else if (wr_hit) begin
      if (reg_addr == rbr_pkg::OFF_PIN_SEL_A)
        pin_a_r <= reg_wdata;
      if (reg_addr == rbr_pkg::OFF_PIN_SEL_B)
        pin_b_r <= reg_wdata;
      if (reg_addr == rbr_pkg::OFF_PIN_PULL)
        pull_r <= (reg_wdata & rbr_pkg::MSK_PIN_PULL) |
                  (rbr_pkg::RST_PIN_PULL & ~rbr_pkg::MSK_PIN_PULL);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_en_r     <= rbr_pkg::RST_INT_ENABLE;
      fifo_start_r <= rbr_pkg::RST_FIFO_START;
      fifo_mode_r  <= rbr_pkg::RST_FIFO_MODE;
      preamble_r   <= rbr_pkg::RST_PREAMBLE;
      pkt_r        <= rbr_pkg::RST_PKT_CTRL;
      misc_r       <= rbr_pkg::RST_MISC_CTRL;
    end else if (sw_reset) begin
      int_en_r     <= rbr_pkg::RST_INT_ENABLE;
      fifo_start_r <= rbr_pkg::RST_FIFO_START;
      fifo_mode_r  <= rbr_pkg::RST_FIFO_MODE;
      preamble_r   <= rbr_pkg::RST_PREAMBLE;
      pkt_r        <= rbr_pkg::RST_PKT_CTRL;
      misc_r       <= rbr_pkg::RST_MISC_CTRL;
    end else if (wr_hit) begin
      case (reg_addr)
        rbr_pkg::OFF_INT_ENABLE: int_en_r <= reg_wdata;
        rbr_pkg::OFF_FIFO_START:
          fifo_start_r <= reg_wdata & rbr_pkg::MSK_FIFO_START;
        rbr_pkg::OFF_FIFO_MODE:
          fifo_mode_r <= reg_wdata & rbr_pkg::MSK_FIFO_MODE;
        rbr_pkg::OFF_PREAMBLE:   preamble_r <= reg_wdata;
        rbr_pkg::OFF_PKT_CTRL:
          pkt_r <= reg_wdata & rbr_pkg::MSK_PKT_CTRL;
        rbr_pkg::OFF_MISC_CTRL:  misc_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      rbr_pkg::OFF_INT_ENABLE: rdata_nxt = int_en_r;
      rbr_pkg::OFF_INT_FLAGS:  rdata_nxt = flags_r;
      rbr_pkg::OFF_PIN_SEL_A:  rdata_nxt = pin_a_r;
      rbr_pkg::OFF_PIN_SEL_B:  rdata_nxt = pin_b_r;
      rbr_pkg::OFF_PIN_PULL:   rdata_nxt = pull_r;
      rbr_pkg::OFF_FIFO_START: rdata_nxt = fifo_start_r;
      rbr_pkg::OFF_FIFO_MODE:  rdata_nxt = fifo_mode_r;
      rbr_pkg::OFF_PREAMBLE:   rdata_nxt = preamble_r;
      rbr_pkg::OFF_PKT_CTRL:   rdata_nxt = pkt_r;
      rbr_pkg::OFF_MISC_CTRL:  rdata_nxt = misc_r;
      default:                 rdata_nxt = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
  end

  assign irq_req = |(flags_r & int_en_r);

  // two-stage synchroniser on the general pin inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gio_s1_r <= 4'h0;
      gio_s2_r <= 4'h0;
    end else begin
      gio_s1_r <= gio_i;
      gio_s2_r <= gio_s1_r;
    end
  end

  // 3-bit selects zero-extend, so 111 lands on the unused code 0111
  assign pin_fn[0] = {1'b0, pin_a_r[2:0]};
  assign pin_fn[1] = {1'b0, pin_a_r[5:3]};
  assign pin_fn[2] = pin_b_r[3:0];
  assign pin_fn[3] = pin_b_r[7:4];

  logic [3:0] pin_val;
  logic [3:0] pin_en;
  logic [3:0] tx_in_hit;
  logic [3:0] tmr_in_hit;

  for (genvar p = 0; p < 4; p++) begin : g_pin
    always_comb begin
      pin_val[p]    = 1'b0;
      pin_en[p]     = 1'b1;
      tx_in_hit[p]  = 1'b0;
      tmr_in_hit[p] = 1'b0;
      case (rbr_pkg::rbr_pin_fn_t'(pin_fn[p]))
        rbr_pkg::PF_SDO: begin
          pin_val[p] = sdo_data;
          pin_en[p]  = ~pull_r[7] | sdo_active;
        end
        rbr_pkg::PF_DIRECT_BIDIR_DATA: begin
          pin_val[p]   = direct_rx_data;
          pin_en[p]    = rx_mode;
          tx_in_hit[p] = ~rx_mode & gio_s2_r[p];
        end
        rbr_pkg::PF_TXD: begin
          pin_en[p]    = 1'b0;
          tx_in_hit[p] = gio_s2_r[p];
        end
        rbr_pkg::PF_RXD:    pin_val[p] = direct_rx_data;
        rbr_pkg::PF_IRQ:    pin_val[p] = int_out_pol ? irq_req : ~irq_req;
        rbr_pkg::PF_TMR_CLK: begin
          pin_en[p]     = 1'b0;
          tmr_in_hit[p] = gio_s2_r[p];
        end
        rbr_pkg::PF_TX_BIT_CLOCK:  pin_val[p] = tx_bit_clock;
        rbr_pkg::PF_RX_RECOVERED_CLOCK:  pin_val[p] = rx_recovered_clock;
        rbr_pkg::PF_XCLK:   pin_val[p] = divided_crystal_clock;
        rbr_pkg::PF_LOW_SPEED_RC_OSC:   pin_val[p] = low_speed_rc_osc;
        rbr_pkg::PF_PA_EN:  pin_val[p] = ext_power_amp_enable;
        rbr_pkg::PF_LNA_EN: pin_val[p] = ext_low_noise_amp_enable;
        rbr_pkg::PF_TXRX_BIT_CLOCK:
          pin_val[p] = rx_mode ? rx_recovered_clock : tx_bit_clock;
        rbr_pkg::PF_PDB:    pin_val[p] = power_down_bar_out;
        default:            pin_en[p]  = 1'b0;
      endcase
      // pins 1 and 2 only reach the lower eight codes
      if (p < 2 && pin_fn[p][3])
        pin_en[p] = 1'b0;
    end
  end

  // pin and setting outputs are registered, costing one cycle of delay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gio_o              <= 4'h0;
      gio_oe             <= 4'h0;
      direct_tx_data     <= 1'b0;
      ext_timer_clock_in <= 1'b0;
    end else begin
      gio_o              <= pin_val;
      gio_oe             <= pin_en;
      direct_tx_data     <= |tx_in_hit;
      ext_timer_clock_in <= |tmr_in_hit;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_pins_pullup_enable   <= 4'h0;
      serial_pins_pullup_enable    <= 1'b0;
      pad_drive_strength           <= 2'h0;
      tx_fifo_start_addr           <= 6'h00;
      rx_length_byte_store_enable  <= 1'b0;
      fifo_unlimited_length_enable <= 1'b0;
      tx_preamble_words            <= 9'h000;
      payload_header_top           <= 8'h00;
      trailer_enable               <= 1'b0;
      whitening_format             <= 2'h0;
      sync_word_len                <= 4'h0;
      rx_detect_source             <= 2'h0;
    end else begin
      general_pins_pullup_enable   <= pull_r[4:1];
      serial_pins_pullup_enable    <= pull_r[6];
      pad_drive_strength           <= pin_a_r[7:6];
      tx_fifo_start_addr           <= fifo_start_r[5:0];
      rx_length_byte_store_enable  <= fifo_mode_r[4];
      fifo_unlimited_length_enable <= fifo_mode_r[3];
      tx_preamble_words <= {1'b0, preamble_r} + 9'h001;
      payload_header_top <= misc_r[7] ?
                            {pkt_r[7:6], 6'h00} : 8'h00;
      trailer_enable   <= pkt_r[5];
      whitening_format <= {misc_r[6], pkt_r[4]};
      sync_word_len <= {1'b0, pkt_r[3:2], misc_r[5]} + 4'h1;
      rx_detect_source <= misc_r[3:2];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_clear_sel_flag: assert property (
    (reg_wr && reg_addr == rbr_pkg::OFF_INT_FLAGS && !sw_reset &&
     flag_set == 8'h00)
    |=> flags_r == ($past(flags_r) &
                    ~($past(misc_r[1]) ? $past(reg_wdata) :
                      ~$past(reg_wdata))))
    else $error("flag clear not per polarity");

  chk_set_beats_clr: assert property (
    (!sw_reset && ev_tx_done) |=> flags_r[rbr_pkg::BIT_TX_DONE])
    else $error("tx done event lost");

  chk_cycle_flag: assert property (
    (!sw_reset && ev_cycle_timer_full) |=> flags_r[rbr_pkg::BIT_CYCLE])
    else $error("cycle timer flag not set");

  chk_rx_done_err: assert property (
    (!sw_reset && ev_rx_fail && !flags_r[rbr_pkg::BIT_RX_DONE])
    |=> !flags_r[rbr_pkg::BIT_RX_DONE] && flags_r[rbr_pkg::BIT_RX_ERR])
    else $error("rx done set despite error");

  chk_irq_pin_level: assert property (
    (pin_a_r[2:0] == 3'h5) |=>
    gio_o[0] == ($past(misc_r[0]) ? $past(irq_req) : !$past(irq_req)))
    else $error("interrupt pin level wrong");

  chk_read_timing: assert property (
    (reg_rd && reg_addr == rbr_pkg::OFF_INT_ENABLE)
    |=> reg_rdata == $past(int_en_r) ##1
        ($past(reg_rd) || reg_rdata == 8'h00))
    else $error("read data timing wrong");

  chk_pin_keep_swrst: assert property (
    (sw_reset && !reg_wr) |=> $stable(pin_a_r) && $stable(pull_r))
    else $error("pin setting lost on soft reset");

  chk_sync_len: assert property (
    rst_n |=> sync_word_len ==
    {1'b0, $past(pkt_r[3:2]), $past(misc_r[5])} + 4'h1)
    else $error("sync length wrong");

  chk_preamble: assert property (
    rst_n |=> tx_preamble_words == {1'b0, $past(preamble_r)} + 9'h001)
    else $error("preamble word count wrong");

  chk_auto_cal: assert property (
    (auto_cal_en && !sw_reset && ev_vco_cal_done && !rc_seen_r &&
     !ev_rc_cal_done && !reg_wr) |=> vco_seen_r)
    else $error("vco calibration completion lost");

endmodule : rbr_regs
`default_nettype wire

// ==== test/rbr_host.sv ====
// host model that drives the register port of the baseband group
`timescale 1ns/1ps
`default_nettype none
module rbr_host (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write, also the way flags are cleared
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // released data must not keep the old value
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : rbr_host
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench of the baseband register group
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk, rst_n, sw_reset, reg_wr, reg_rd, rx_mode;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rx_remaining_len;
  logic        burst_tx_mode, burst_rx_mode, tx_data_pending;
  logic        crc_field_enable, direct_tx_data, ext_timer_clock_in;
  logic        fifo_unlimited_length_enable, trailer_enable;
  logic        serial_pins_pullup_enable, rx_length_byte_store_enable;
  logic [6:0]  tx_fifo_level, rx_fifo_space;
  logic [3:0]  gio_i, gio_o, gio_oe, general_pins_pullup_enable;
  logic [3:0]  sync_word_len;
  logic [1:0]  pad_drive_strength, whitening_format, rx_detect_source;
  logic [5:0]  tx_fifo_start_addr;
  logic [8:0]  tx_preamble_words;
  logic [7:0]  payload_header_top;
  logic [11:0] ev;
  logic [9:0]  src;
  int          failures, checks;
  logic [7:0]  rv [11] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h7f, 8'h00,
                           8'h01, 8'h01, 8'h24, 8'h09, 8'h00};
  logic [3:0]  cd [10] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he,
                           4'hf, 4'h1, 4'h4};
  logic [3:0]  sx [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h0,
                           4'h6, 4'h7, 4'h8};

  rbr_regs dut (
    .ref_clk, .rst_n, .sw_reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ev_ack_tx_fail(ev[7]),
    .ev_cycle_timer_full(ev[6]), .burst_tx_mode, .burst_rx_mode,
    .tx_fifo_level, .tx_data_pending, .rx_fifo_space,
    .rx_remaining_len, .ev_rx_fail(ev[4]), .ev_crc_mismatch(ev[5]),
    .crc_field_enable, .ev_rx_overwrite(ev[8]),
    .ev_carrier_detect(ev[9]), .ev_sync_detect(ev[3]),
    .ev_low_speed_rc_osc_cal_done(ev[2]), .ev_vco_cal_done(ev[10]),
    .ev_rc_cal_done(ev[11]), .ev_rx_finished(ev[1]),
    .ev_tx_done(ev[0]), .rx_mode, .sdo_data(src[7]),
    .sdo_active(src[9]), .direct_rx_data(src[8]),
    .tx_bit_clock(src[0]), .rx_recovered_clock(src[1]),
    .divided_crystal_clock(src[2]), .low_speed_rc_osc(src[3]),
    .ext_power_amp_enable(src[4]), .ext_low_noise_amp_enable(src[5]),
    .power_down_bar_out(src[6]), .gio_i, .gio_o, .gio_oe,
    .general_pins_pullup_enable, .serial_pins_pullup_enable,
    .pad_drive_strength, .direct_tx_data, .ext_timer_clock_in,
    .tx_fifo_start_addr, .rx_length_byte_store_enable,
    .fifo_unlimited_length_enable, .tx_preamble_words,
    .payload_header_top, .trailer_enable, .whitening_format,
    .sync_word_len, .rx_detect_source
  );
  rbr_host host (
    .ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );

  always #2 ref_clk = ~ref_clk;

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    cmp(d, e);
  endtask : rc
  task automatic pulse(input logic [11:0] v);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= '0;
  endtask : pulse
  // levels need sync plus output register before they show
  task automatic settle;
    repeat (4) @(posedge ref_clk);
  endtask : settle
  task automatic test_done;
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    #100000;
    failures++;
    test_done();
  end

  initial begin
    failures = 0;
    checks = 0;
    {ref_clk, rst_n, sw_reset, burst_tx_mode, burst_rx_mode} = '0;
    {tx_data_pending, crc_field_enable, rx_mode, gio_i, ev, src} = '0;
    {tx_fifo_level, rx_fifo_space, rx_remaining_len} = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++) rc(i[7:0], rv[i]);
    cmp(tx_preamble_words, 9'h002);
    cmp(sync_word_len, 4'h3);
    cmp({serial_pins_pullup_enable, pad_drive_strength}, 3'h5);
    host.wr(8'h00, 8'hff);
    for (int i = 0; i < 8; i++) begin
      if (i == 5) continue;
      pulse(12'h001 << i);
      rc(8'h01, 8'h01 << i);
      host.wr(8'h01, ~(8'h01 << i));
      rc(8'h01, 8'h00);
    end
    pulse(12'h012);
    rc(8'h01, 8'h10);
    host.wr(8'h01, 8'h00);
    pulse(12'h220);
    rc(8'h01, 8'h00);
    crc_field_enable <= 1'b1;
    pulse(12'h020);
    rc(8'h01, 8'h10);
    host.wr(8'h01, 8'h00);
    pulse(12'h100);
    rc(8'h01, 8'h10);
    host.wr(8'h01, 8'h00);
    host.wr(8'h09, 8'h11);
    pulse(12'h600);
    rc(8'h01, 8'h08);
    pulse(12'h800);
    rc(8'h01, 8'h0c);
    burst_tx_mode <= 1'b1;
    tx_data_pending <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      tx_fifo_level <= 7'h04 << k;
      host.wr(8'h06, 8'h04 | k[7:0]);
      host.wr(8'h01, 8'h00);
      rc(8'h01, 8'h00);
      tx_fifo_level <= (7'h04 << k) - 7'h01;
      rc(8'h01, 8'h20);
    end
    burst_tx_mode <= 1'b0;
    burst_rx_mode <= 1'b1;
    rx_remaining_len <= 8'h21;
    rx_fifo_space <= 7'h20;
    host.wr(8'h01, 8'h00);
    rx_fifo_space <= 7'h1f;
    rc(8'h01, 8'h20);
    burst_rx_mode <= 1'b0;
    host.wr(8'h01, 8'h00);
    host.wr(8'h09, 8'h13);
    pulse(12'h003);
    host.wr(8'h01, 8'h01);
    rc(8'h01, 8'h02);
    host.wr(8'h00, 8'h00);
    host.wr(8'h02, 8'h45);
    settle();
    cmp({gio_oe[0], gio_o[0]}, 2'b10);
    host.wr(8'h00, 8'h02);
    settle();
    cmp({gio_oe[0], gio_o[0]}, 2'b11);
    host.wr(8'h09, 8'h12);
    settle();
    cmp({gio_oe[0], gio_o[0]}, 2'b10);
    host.wr(8'h01, 8'h02);
    settle();
    cmp({gio_oe[0], gio_o[0]}, 2'b11);
    for (int k = 0; k < 10; k++) begin
      host.wr(8'h03, {4'h0, cd[k]});
      src <= 10'h001 << sx[k];
      settle();
      cmp({gio_oe[2], gio_o[2]}, 2'b11);
      src <= '0;
      settle();
      cmp({gio_oe[2], gio_o[2]}, 2'b10);
    end
    rx_mode <= 1'b1;
    host.wr(8'h03, 8'h0e);
    src <= 10'h002;
    settle();
    cmp({gio_oe[2], gio_o[2]}, 2'b11);
    gio_i <= 4'h4;
    host.wr(8'h03, 8'h03);
    settle();
    cmp({gio_oe[2], direct_tx_data}, 2'b01);
    host.wr(8'h03, 8'h06);
    settle();
    cmp({gio_oe[2], ext_timer_clock_in}, 2'b01);
    host.wr(8'h03, 8'hf7);
    src <= 10'h040;
    settle();
    cmp({gio_oe, gio_o[3], direct_tx_data}, 6'h26);
    host.wr(8'h04, 8'h00);
    rc(8'h04, 8'h21);
    host.wr(8'h05, 8'hff);
    host.wr(8'h06, 8'hff);
    host.wr(8'h07, 8'hff);
    host.wr(8'h08, 8'hff);
    host.wr(8'h09, 8'he9);
    rc(8'h05, 8'h3f);
    rc(8'h08, 8'hfc);
    cmp({serial_pins_pullup_enable, general_pins_pullup_enable}, 5'h0);
    cmp(tx_fifo_start_addr, 6'h3f);
    cmp({rx_length_byte_store_enable, fifo_unlimited_length_enable},
        2'h3);
    cmp(tx_preamble_words, 9'h100);
    cmp({payload_header_top, trailer_enable}, 9'h181);
    cmp(whitening_format, 2'h3);
    cmp(rx_detect_source, 2'h2);
    cmp(sync_word_len, 4'h8);
    @(posedge ref_clk);
    sw_reset <= 1'b1;
    @(posedge ref_clk);
    sw_reset <= 1'b0;
    rc(8'h04, 8'h21);
    rc(8'h03, 8'hf7);
    rc(8'h07, 8'h01);
    rc(8'h09, 8'h09);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
